// >>> pfc_defines.svh
// Behaviour
// - A command write drives write strobe low while chip select is held low.
// - Array data is read only while select and output gate are both low.
// - Host programs a byte only into an erased sector; the code checks only that the target byte reads erased.
// - Byte program is three unlock writes then one address and data write.
// - Sector erase is six writes, last carries code 30h and sector address.
// - Chip erase is six writes, last writes code 10h to address 5555h.
// - On a doubtful status read, read twice more and need both valid.
// - Whole byte is trusted only after a 1 us settling interval.
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

`define PFC_CLK_NS 10
// Bus cycle timing, least times rounded up
`define PFC_WE_LOW_NS 40
`define PFC_WE_LOW_CYC ((`PFC_WE_LOW_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_ACCESS_NS 90
`define PFC_ACCESS_CYC ((`PFC_ACCESS_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
// Longest program time, rounded down
`define PFC_PROG_MAX_NS 20000
`define PFC_PROG_MAX_CYC (`PFC_PROG_MAX_NS / `PFC_CLK_NS)
// Settling interval after polling bit turns true, rounded up
`define PFC_SETTLE_NS 1000
`define PFC_SETTLE_CYC ((`PFC_SETTLE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)

// Command codes and unlock addresses
`define PFC_UNLOCK_A1 16'h5555
`define PFC_UNLOCK_A2 16'h2aaa
`define PFC_CODE_UNLOCK1 8'haa
`define PFC_CODE_UNLOCK2 8'h55
`define PFC_CODE_PROG 8'ha0
`define PFC_CODE_ERASE 8'h80
`define PFC_CODE_SECTOR 8'h30
`define PFC_CODE_CHIP 8'h10
`define PFC_ERASED 8'hff
`define PFC_PROG_LAST 3'h3
`define PFC_ERASE_LAST 3'h5
`define PFC_SECTOR_BITS 12

`endif

// >>> pfc_pkg.sv
package pfc_pkg;
  typedef enum logic [1:0] {
    PFC_OP_READ = 2'b00,
    PFC_OP_PROG = 2'b01,
    PFC_OP_SECT = 2'b10,
    PFC_OP_CHIP = 2'b11
  } pfc_op_e;

  typedef enum logic [2:0] {
    PFC_BC_IDLE = 3'b000,
    PFC_BC_SETUP = 3'b001,
    PFC_BC_STROBE = 3'b010,
    PFC_BC_HOLD = 3'b011,
    PFC_BC_GAP = 3'b100
  } pfc_bc_e;

  typedef enum logic [2:0] {
    PFC_M_IDLE = 3'b000,
    PFC_M_READ = 3'b001,
    PFC_M_CHECK = 3'b010,
    PFC_M_SEQ = 3'b011,
    PFC_M_POLL = 3'b100,
    PFC_M_SETTLE = 3'b101,
    PFC_M_CONFIRM = 3'b110,
    PFC_M_DONE = 3'b111
  } pfc_main_e;
endpackage : pfc_pkg

// >>> pfc_bus_cycle.sv
`timescale 1ns/10ps
`include "pfc_defines.svh"
module pfc_bus_cycle #(
  parameter int ADDR_W = 19
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Cycle request
  input wire logic start,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_i
);
  pfc_pkg::pfc_bc_e state_q;
  logic [3:0] cnt_q;
  logic wr_q;

  assign busy = (state_q != pfc_pkg::PFC_BC_IDLE);
  assign done = (state_q == pfc_pkg::PFC_BC_GAP);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= pfc_pkg::PFC_BC_IDLE;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
    end else begin
      unique case (state_q)
        pfc_pkg::PFC_BC_IDLE: begin
          if (start) begin
            wr_q <= wr;
            state_q <= pfc_pkg::PFC_BC_SETUP;
          end
        end
        pfc_pkg::PFC_BC_SETUP: begin
          cnt_q <= wr_q ? 4'(`PFC_WE_LOW_CYC - 1) : 4'(`PFC_ACCESS_CYC - 1);
          state_q <= pfc_pkg::PFC_BC_STROBE;
        end
        pfc_pkg::PFC_BC_STROBE: begin
          if (cnt_q == 4'h0) begin
            state_q <= pfc_pkg::PFC_BC_HOLD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        pfc_pkg::PFC_BC_HOLD: state_q <= pfc_pkg::PFC_BC_GAP;
        pfc_pkg::PFC_BC_GAP: state_q <= pfc_pkg::PFC_BC_IDLE;
        default: state_q <= pfc_pkg::PFC_BC_IDLE;
      endcase
    end
  end

  // Select falls a cycle before either strobe, so the strobe edge is always the later one
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      if (state_q == pfc_pkg::PFC_BC_IDLE && start) begin
        flash_ce_n <= 1'b0;
      end
      if (state_q == pfc_pkg::PFC_BC_SETUP) begin
        flash_we_n <= !wr_q;
        flash_oe_n <= wr_q;
      end
      if (state_q == pfc_pkg::PFC_BC_STROBE && cnt_q == 4'h0) begin
        flash_we_n <= 1'b1;
        flash_oe_n <= 1'b1;
      end
      if (state_q == pfc_pkg::PFC_BC_HOLD) begin
        flash_ce_n <= 1'b1;
      end
    end
  end

  // Address and data stay put from select low until after select high
  always_ff @(posedge clk) begin
    if (reset) begin
      flash_addr <= '0;
      flash_dq_o <= 8'h00;
      flash_dq_oe <= 1'b0;
    end else if (state_q == pfc_pkg::PFC_BC_IDLE && start) begin
      flash_addr <= addr;
      flash_dq_o <= wdata;
      flash_dq_oe <= wr;
    end else if (state_q == pfc_pkg::PFC_BC_GAP) begin
      flash_dq_oe <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (state_q == pfc_pkg::PFC_BC_STROBE && cnt_q == 4'h0 && !wr_q) begin
      rdata <= flash_dq_i;
    end
  end
endmodule : pfc_bus_cycle

// >>> pfc_flash_host.sv
`timescale 1ns/10ps
`include "pfc_defines.svh"
module pfc_flash_host #(
  parameter int ADDR_W = 19,
  parameter int unsigned ERASE_MAX_CYC = 32'd10000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire pfc_pkg::pfc_op_e cmd_op,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_data,
  // Response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_error,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_i
);
  pfc_pkg::pfc_main_e state_q;
  pfc_pkg::pfc_op_e op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q;
  logic [2:0] step_q;
  logic [31:0] wait_q;
  logic conf_q;
  logic pend_q;
  logic need_cycle;
  logic bc_start;
  logic bc_wr;
  logic [ADDR_W-1:0] bc_addr;
  logic [7:0] bc_wdata;
  logic bc_busy;
  logic bc_done;
  logic [7:0] bc_rdata;
  logic last_step;
  logic [31:0] wait_max;

  function automatic logic [ADDR_W-1:0] sector_base(input logic [ADDR_W-1:0] a);
    sector_base = a & ~ADDR_W'((1 << `PFC_SECTOR_BITS) - 1);
  endfunction : sector_base

  function automatic logic is_last(input pfc_pkg::pfc_op_e op, input logic [2:0] idx);
    is_last = (op == pfc_pkg::PFC_OP_PROG) ? (idx == `PFC_PROG_LAST) : (idx == `PFC_ERASE_LAST);
  endfunction : is_last

  // Unlock words are fixed; any deviation would make the device drop the sequence
  function automatic logic [ADDR_W-1:0] step_addr(input pfc_pkg::pfc_op_e op,
      input logic [2:0] idx, input logic [ADDR_W-1:0] tgt);
    if (is_last(op, idx)) begin
      unique case (op)
        pfc_pkg::PFC_OP_SECT: step_addr = sector_base(tgt);
        pfc_pkg::PFC_OP_CHIP: step_addr = ADDR_W'(`PFC_UNLOCK_A1);
        default: step_addr = tgt;
      endcase
    end else if (idx == 3'h1 || idx == 3'h4) begin
      step_addr = ADDR_W'(`PFC_UNLOCK_A2);
    end else begin
      step_addr = ADDR_W'(`PFC_UNLOCK_A1);
    end
  endfunction : step_addr

  function automatic logic [7:0] step_data(input pfc_pkg::pfc_op_e op,
      input logic [2:0] idx, input logic [7:0] d);
    if (is_last(op, idx)) begin
      unique case (op)
        pfc_pkg::PFC_OP_SECT: step_data = `PFC_CODE_SECTOR;
        pfc_pkg::PFC_OP_CHIP: step_data = `PFC_CODE_CHIP;
        default: step_data = d;
      endcase
    end else if (idx == 3'h1 || idx == 3'h4) begin
      step_data = `PFC_CODE_UNLOCK2;
    end else if (idx == 3'h2) begin
      step_data = (op == pfc_pkg::PFC_OP_PROG) ? `PFC_CODE_PROG : `PFC_CODE_ERASE;
    end else begin
      step_data = `PFC_CODE_UNLOCK1;
    end
  endfunction : step_data

  // Only the top bit is trusted while the operation may be finishing
  function automatic logic poll_done(input pfc_pkg::pfc_op_e op, input logic [7:0] rd,
      input logic [7:0] d);
    if (op == pfc_pkg::PFC_OP_PROG) begin
      poll_done = (rd[7] == d[7]);
    end else begin
      poll_done = rd[7];
    end
  endfunction : poll_done

  function automatic logic byte_valid(input pfc_pkg::pfc_op_e op, input logic [7:0] rd,
      input logic [7:0] d);
    if (op == pfc_pkg::PFC_OP_PROG) begin
      byte_valid = (rd == d);
    end else begin
      byte_valid = (rd == `PFC_ERASED);
    end
  endfunction : byte_valid

  assign cmd_ready = (state_q == pfc_pkg::PFC_M_IDLE);
  assign rsp_valid = (state_q == pfc_pkg::PFC_M_DONE);
  assign last_step = is_last(op_q, step_q);
  assign wait_max = (op_q == pfc_pkg::PFC_OP_PROG) ? 32'(`PFC_PROG_MAX_CYC) : ERASE_MAX_CYC;

  // While busy, the only bus traffic is status reads of the target address
  always_comb begin
    need_cycle = 1'b0;
    bc_wr = 1'b0;
    bc_addr = addr_q;
    bc_wdata = 8'h00;
    unique case (state_q)
      pfc_pkg::PFC_M_READ, pfc_pkg::PFC_M_CHECK: need_cycle = 1'b1;
      pfc_pkg::PFC_M_SEQ: begin
        need_cycle = 1'b1;
        bc_wr = 1'b1;
        bc_addr = step_addr(op_q, step_q, addr_q);
        bc_wdata = step_data(op_q, step_q, data_q);
      end
      pfc_pkg::PFC_M_POLL, pfc_pkg::PFC_M_CONFIRM: need_cycle = 1'b1;
      default: need_cycle = 1'b0;
    endcase
  end

  assign bc_start = need_cycle && !bc_busy && !pend_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      pend_q <= 1'b0;
    end else if (bc_start) begin
      pend_q <= 1'b1;
    end else if (bc_done) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      op_q <= pfc_pkg::PFC_OP_READ;
      addr_q <= '0;
      data_q <= 8'h00;
    end else if (cmd_ready && cmd_valid) begin
      op_q <= cmd_op;
      addr_q <= cmd_addr;
      data_q <= cmd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= pfc_pkg::PFC_M_IDLE;
      step_q <= 3'h0;
      conf_q <= 1'b0;
      rsp_data <= 8'h00;
      rsp_error <= 1'b0;
    end else begin
      unique case (state_q)
        pfc_pkg::PFC_M_IDLE: begin
          step_q <= 3'h0;
          conf_q <= 1'b0;
          rsp_error <= 1'b0;
          if (cmd_valid) begin
            unique case (cmd_op)
              pfc_pkg::PFC_OP_READ: state_q <= pfc_pkg::PFC_M_READ;
              pfc_pkg::PFC_OP_PROG: state_q <= pfc_pkg::PFC_M_CHECK;
              default: state_q <= pfc_pkg::PFC_M_SEQ;
            endcase
          end
        end
        pfc_pkg::PFC_M_READ: begin
          if (bc_done) begin
            rsp_data <= bc_rdata;
            state_q <= pfc_pkg::PFC_M_DONE;
          end
        end
        // Checks only the target byte, not the whole sector, to keep the cost low
        pfc_pkg::PFC_M_CHECK: begin
          if (bc_done) begin
            rsp_data <= bc_rdata;
            if (bc_rdata != `PFC_ERASED) begin
              rsp_error <= 1'b1;
              state_q <= pfc_pkg::PFC_M_DONE;
            end else begin
              state_q <= pfc_pkg::PFC_M_SEQ;
            end
          end
        end
        pfc_pkg::PFC_M_SEQ: begin
          if (bc_done) begin
            if (last_step) begin
              state_q <= pfc_pkg::PFC_M_POLL;
            end else begin
              step_q <= step_q + 3'h1;
            end
          end
        end
        pfc_pkg::PFC_M_POLL: begin
          if (bc_done) begin
            rsp_data <= bc_rdata;
            if (poll_done(op_q, bc_rdata, data_q)) begin
              state_q <= pfc_pkg::PFC_M_SETTLE;
            end else if (wait_q >= wait_max) begin
              rsp_error <= 1'b1;
              state_q <= pfc_pkg::PFC_M_DONE;
            end
          end
        end
        pfc_pkg::PFC_M_SETTLE: begin
          if (wait_q >= 32'(`PFC_SETTLE_CYC)) begin
            state_q <= pfc_pkg::PFC_M_CONFIRM;
          end
        end
        pfc_pkg::PFC_M_CONFIRM: begin
          if (bc_done) begin
            rsp_data <= bc_rdata;
            if (!byte_valid(op_q, bc_rdata, data_q)) begin
              rsp_error <= 1'b1;
              state_q <= pfc_pkg::PFC_M_DONE;
            end else if (conf_q) begin
              state_q <= pfc_pkg::PFC_M_DONE;
            end else begin
              conf_q <= 1'b1;
            end
          end
        end
        pfc_pkg::PFC_M_DONE: state_q <= pfc_pkg::PFC_M_IDLE;
        default: state_q <= pfc_pkg::PFC_M_IDLE;
      endcase
    end
  end

  // One counter serves the busy timeout and the settling interval
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_q <= 32'h0;
    end else if (state_q == pfc_pkg::PFC_M_POLL) begin
      if (bc_done && poll_done(op_q, bc_rdata, data_q)) begin
        wait_q <= 32'h0;
      end else if (wait_q != 32'hffffffff) begin
        wait_q <= wait_q + 32'h1;
      end
    end else if (state_q == pfc_pkg::PFC_M_SETTLE) begin
      wait_q <= wait_q + 32'h1;
    end else begin
      wait_q <= 32'h0;
    end
  end

  pfc_bus_cycle #(
    .ADDR_W(ADDR_W)
  ) u_cycle (
    .clk(clk),
    .reset(reset),
    .start(bc_start),
    .wr(bc_wr),
    .addr(bc_addr),
    .wdata(bc_wdata),
    .busy(bc_busy),
    .done(bc_done),
    .rdata(bc_rdata),
    .flash_addr(flash_addr),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i)
  );
endmodule : pfc_flash_host

// >>> pfc_flash_model.sv
`timescale 1ns/10ps
`include "pfc_defines.svh"
module pfc_flash_model #(
  parameter int ADDR_W = 19,
  parameter real PROG_NS = 5000.0,
  parameter real ERASE_NS = 10000.0
) (
  // Flash pins
  input wire logic [ADDR_W-1:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out
);
  logic [7:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] lat_a;
  logic [7:0] prog_d;
  logic [7:0] v;
  logic wr_on = 1'h0;
  logic toggle_status_bit = 1'h0;
  int step = 0;
  int busy = 0;
  realtime done_t = -1.0e6;

  initial dq_out = 8'h00;

  function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : `PFC_ERASED;
  endfunction : rd

  function automatic bit is(input logic [ADDR_W-1:0] a, input logic [15:0] ea,
                            input logic [7:0] d, input logic [7:0] ed);
    return a == ADDR_W'(ea) && d == ed;
  endfunction : is

  task automatic start(input int kind, input real ns);
    step = 0;
    busy = kind;
    done_t = $realtime + ns;
  endtask : start

  task automatic take(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bit ok;
    case (step)
      0, 3: ok = is(a, `PFC_UNLOCK_A1, d, `PFC_CODE_UNLOCK1);
      1, 4: ok = is(a, `PFC_UNLOCK_A2, d, `PFC_CODE_UNLOCK2);
      2: ok = is(a, `PFC_UNLOCK_A1, d, `PFC_CODE_PROG) || is(a, `PFC_UNLOCK_A1, d, `PFC_CODE_ERASE);
      5: ok = d == `PFC_CODE_SECTOR || is(a, `PFC_UNLOCK_A1, d, `PFC_CODE_CHIP);
      6: ok = 1'h1;
      default: ok = 1'h0;
    endcase
    if (!ok) begin
      step = 0;
    end else if (step == 2 && d == `PFC_CODE_PROG) begin
      step = 6;
    end else if (step == 6) begin
      mem[a] = rd(a) & d;
      prog_d = d;
      start(1, PROG_NS);
    end else if (step == 5) begin
      if (d == `PFC_CODE_CHIP) begin
        mem.delete();
      end else begin
        foreach (mem[k]) begin
          if (k[ADDR_W-1:`PFC_SECTOR_BITS] == a[ADDR_W-1:`PFC_SECTOR_BITS]) mem[k] = `PFC_ERASED;
        end
      end
      start(2, ERASE_NS);
    end else begin
      step = step + 1;
    end
  endtask : take

  // Pulse opens at the later falling edge, and only with the output gate high
  always @(negedge we_n or negedge ce_n) begin
    if (!we_n && !ce_n && oe_n) begin
      lat_a = addr;
      wr_on = 1'h1;
    end
  end

  always @(posedge we_n or posedge ce_n) begin
    if (busy != 0 && $realtime >= done_t) busy = 0;
    if (wr_on) begin
      wr_on = 1'h0;
      if (busy == 0) take(lat_a, dq_in);
    end
  end

  // A released bus changes on every edge, so a stale byte cannot pass for data
  always @(negedge oe_n or negedge ce_n or posedge oe_n or posedge ce_n) begin
    if (busy != 0 && $realtime >= done_t) busy = 0;
    v = rd(addr);
    if (ce_n || oe_n) dq_out = ~dq_out;
    else if (busy == 1) dq_out = {~prog_d[7], toggle_status_bit, 6'h2a};
    else if (busy == 2) dq_out = {1'h0, toggle_status_bit, 6'h15};
    else if ($realtime < done_t + 1000.0) dq_out = {v[7], ~v[6:0]};
    else dq_out = v;
    if (!ce_n && !oe_n) toggle_status_bit = ~toggle_status_bit;
  end
endmodule : pfc_flash_model

// >>> pfc_flash_host_chk.sv
`timescale 1ns/10ps
module pfc_flash_host_chk #(
  parameter int ADDR_W = 19
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command and response
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire pfc_pkg::pfc_op_e cmd_op,
  input wire logic rsp_valid,
  input wire logic rsp_error,
  // Flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_WE_UNDER_CE: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe low without select or with gate low");
  AST_WE_AFTER_CE: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n))
    else $error("write strobe fell before select");
  AST_WE_PULSE: assert property ($fell(flash_we_n) |-> (!flash_we_n)[*4] ##1 flash_we_n)
    else $error("write pulse length wrong");
  AST_WE_HOLD: assert property (!flash_we_n |=>
    flash_we_n || ($stable(flash_addr) && $stable(flash_dq_o)))
    else $error("address or data moved during write pulse");
  AST_WE_RISE: assert property ($rose(flash_we_n) |->
    !flash_ce_n && flash_dq_oe && $stable(flash_dq_o))
    else $error("data not held at write strobe rise");
  AST_OE_READ: assert property (!flash_oe_n |-> !flash_ce_n && !flash_dq_oe && flash_we_n)
    else $error("output gate low outside a clean read");
  AST_CE_GAP: assert property ($rose(flash_ce_n) |=> flash_ce_n)
    else $error("select gap too short");
  AST_READ_LAT: assert property (cmd_valid && cmd_ready && cmd_op == pfc_pkg::PFC_OP_READ
    |-> ##14 rsp_valid)
    else $error("read answer late or early");
  AST_RSP_PULSE: assert property (rsp_valid |=> !rsp_valid && cmd_ready)
    else $error("response not a single pulse");
  AST_BUSY: assert property (cmd_valid && cmd_ready |=> (!cmd_ready)[*2])
    else $error("command taken while busy");

  cover property (rsp_valid && rsp_error);
  cover property (cmd_valid && cmd_ready && cmd_op == pfc_pkg::PFC_OP_PROG);
  cover property (cmd_valid && cmd_ready && cmd_op == pfc_pkg::PFC_OP_SECT);
  cover property (cmd_valid && cmd_ready && cmd_op == pfc_pkg::PFC_OP_CHIP);
endmodule : pfc_flash_host_chk

bind pfc_flash_host pfc_flash_host_chk #(.ADDR_W(ADDR_W)) i_pfc_flash_host_chk (
  .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
  .rsp_valid(rsp_valid), .rsp_error(rsp_error), .flash_addr(flash_addr),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe));

// >>> pfc_flash_host_bench.sv
`timescale 1ns/10ps
`define PFC_CMP(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("BAD %0t got %h expected %h", $time, g, e); end end
module pfc_flash_host_bench;
  localparam int AW = 19;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic cmd_valid = 1'h0;
  pfc_pkg::pfc_op_e cmd_op = pfc_pkg::PFC_OP_READ;
  logic [AW-1:0] cmd_addr = '0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, rsp_error, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
  logic [AW-1:0] flash_addr, a0, a1;
  logic [7:0] rsp_data, flash_dq_o, flash_dq_i, dev_dq, d0;
  logic [9:0] expq [$];
  logic [9:0] e;
  int failures = 0;
  int checks = 0;
  int seed = 32'h76db;

  always #5 clk = ~clk;
  // Host drive wins only while its enable is up
  assign flash_dq_i = flash_dq_oe ? flash_dq_o : dev_dq;

  pfc_flash_host #(.ADDR_W(AW), .ERASE_MAX_CYC(32'h7d0)) i_pfc_flash_host (
    .clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_error(rsp_error), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_o(flash_dq_o),
    .flash_dq_oe(flash_dq_oe), .flash_dq_i(flash_dq_i));

  pfc_flash_model #(.ADDR_W(AW)) i_pfc_flash_model (
    .addr(flash_addr), .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .dq_in(flash_dq_o), .dq_out(dev_dq));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Expectation word: check data flag, error, data
  task automatic cmd(input pfc_pkg::pfc_op_e op, input logic [AW-1:0] a, input logic [7:0] d,
                     input logic err, input logic chk, input logic [7:0] ed);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_data <= d;
    expq.push_back({chk, err, ed});
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'h1 && n < 5000);
    // A command that is never taken must not slip through as a quiet gap
    if (cmd_ready !== 1'h1) begin
      failures++;
      $display("BAD %0t command never taken", $time);
    end
    cmd_valid <= 1'h0;
  endtask : cmd

  always @(posedge clk) begin
    if (rsp_valid === 1'h1) begin
      if (expq.size() == 0) begin
        failures++;
        $display("BAD %0t response with nothing expected", $time);
      end else begin
        e = expq.pop_front();
        `PFC_CMP(rsp_error, e[8])
        if (e[9]) `PFC_CMP(rsp_data, e[7:0])
      end
    end
  end

  initial begin
    a0 = AW'($random(seed));
    a1 = a0 ^ 19'h01000;
    d0 = 8'($random(seed)) & 8'hfe;
    repeat (16) @(posedge clk);
    reset <= 1'h0;
    cmd(pfc_pkg::PFC_OP_READ, a0, 8'h00, 1'h0, 1'h1, 8'hff);
    cmd(pfc_pkg::PFC_OP_PROG, a0, d0, 1'h0, 1'h1, d0);
    cmd(pfc_pkg::PFC_OP_PROG, a1, d0, 1'h0, 1'h1, d0);
    cmd(pfc_pkg::PFC_OP_READ, a0, 8'h00, 1'h0, 1'h1, d0);
    // Not erased, so the controller must refuse before touching the array
    cmd(pfc_pkg::PFC_OP_PROG, a0, d0, 1'h0 ^ 1'h1, 1'h0, 8'h00);
    cmd(pfc_pkg::PFC_OP_SECT, a0, 8'h00, 1'h0, 1'h1, 8'hff);
    cmd(pfc_pkg::PFC_OP_READ, a0, 8'h00, 1'h0, 1'h1, 8'hff);
    cmd(pfc_pkg::PFC_OP_READ, a1, 8'h00, 1'h0, 1'h1, d0);
    cmd(pfc_pkg::PFC_OP_CHIP, a1, 8'h00, 1'h0, 1'h1, 8'hff);
    repeat (3) cmd(pfc_pkg::PFC_OP_READ, AW'($random(seed)), 8'h00, 1'h0, 1'h1, 8'hff);
    cmd(pfc_pkg::PFC_OP_READ, a1, 8'h00, 1'h0, 1'h1, 8'hff);
    while (expq.size() != 0) @(posedge clk);
    end_of_test();
  end

  // About eight times the expected run, so a hung poll cannot stall forever
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : pfc_flash_host_bench
